// ---- rtl/fpx_pair_xfer.v ----
// two-register transfer decoder between integer core and fp register file
//
// Function
// - double from core pair: second core word to upper half, first to lower
// - double to core pair: upper half to second core reg, lower to first
// - singles from core pair: first word to S(m), second to S(m+1)
// - singles to core pair: S(m) to first core reg, S(m+1) to second
// - single index m is fp register field above the extra low bit
// - transfer acts only when condition in bits 31:28 passes
// - words move bit for bit with no format conversion
// - the two core register numbers are independent, need not be adjacent
// - two-register class; bit 20 clear to coprocessor, set to core
// - bits 11:8 1011 double, 1010 single; bits 7:6 zero, bit 4 one
// - second core reg 19:16, first 15:12, fp field 3:0, low bit 5
// - these are the coprocessor two-register write and read forms
`timescale 1ns/1ps
`include "fpx_regs.vh"
module fpx_pair_xfer #(
    parameter AW = 5,
    parameter DW = 32
) (
    input  wire          clk_sys_i,
    input  wire          nrst_i,
    input  wire          instr_valid_i,
    input  wire [31:0]   instr_i,
    input  wire [3:0]    core_flags_i,
    input  wire [DW-1:0] first_core_data_i,
    input  wire [DW-1:0] second_core_data_i,
    output wire          instr_accept_o,
    output wire          write_done_o,
    output reg           read_valid_o,
    output reg  [DW-1:0] first_core_data_o,
    output reg  [DW-1:0] second_core_data_o,
    output reg  [3:0]    first_core_reg_o,
    output reg  [3:0]    second_core_reg_o
);

    reg           rst_meta;
    reg           rst_n;
    wire [3:0]    cond;
    wire          class_hit;
    wire          prec_double;
    wire          prec_single;
    wire          fixed_ok;
    wire          is_pair;
    reg           cond_pass;
    wire          go;
    wire          dir_to_core;
    wire [AW-1:0] base_idx;
    wire [AW-1:0] next_idx;
    wire [DW-1:0] rd_a;
    wire [DW-1:0] rd_b;
    wire          n_f;
    wire          z_f;
    wire          c_f;
    wire          v_f;

    // named instruction fields
    wire [6:0]    class_field;
    wire [3:0]    prec_field;
    wire [1:0]    zero_field;
    wire          one_bit;
    wire          low_bit;
    wire [3:0]    fp_field;
    wire [3:0]    first_reg_num;
    wire [3:0]    second_reg_num;

    // the four transfer kinds and the two generic forms
    wire          move_double_from_core_pair;
    wire          move_double_to_core_pair;
    wire          move_singles_from_core_pair;
    wire          move_singles_to_core_pair;
    wire          coproc_two_reg_write;
    wire          coproc_two_reg_read;

    // one pass result per condition code
    wire          cc_eq;
    wire          cc_ne;
    wire          cc_cs;
    wire          cc_cc;
    wire          cc_mi;
    wire          cc_pl;
    wire          cc_vs;
    wire          cc_vc;
    wire          cc_hi;
    wire          cc_ls;
    wire          cc_ge;
    wire          cc_lt;
    wire          cc_gt;
    wire          cc_le;

    // datapath overview:
    // - the instruction is decoded straight from instr_i, with no pipeline stage
    // - singles and doubles share one file of 32-bit words; double d is the
    //   pair S(2d) as low half and S(2d+1) as high half
    // - a write uses both file ports in one edge, so both words land together
    // - a read comes out of the file's registered read ports one cycle after
    //   the request, which is why read_valid_o is a registered pulse
    // - the core's register numbers ride alongside the read answer, so the
    //   core needs no memory of which registers it named
    // - nothing here holds status or exception state, so no transfer can
    //   change a flag or raise an exception, whatever bit pattern it moves

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops
    // assertion is asynchronous; release waits two edges so every flop in the
    // block leaves reset on the same edge; instr_accept_o is held low until
    // then, so an instruction offered too early is simply not taken
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // class field of the two-register transfer group
    assign class_field    = instr_i[`FPX_CLASS_HI:`FPX_CLASS_LO];

    // precision and fixed-value fields
    assign prec_field     = instr_i[`FPX_PREC_HI:`FPX_PREC_LO];
    assign zero_field     = instr_i[`FPX_ZERO_HI:`FPX_ZERO_LO];
    assign one_bit        = instr_i[`FPX_ONE_BIT];

    // floating-point register field and its extra low bit
    assign fp_field       = instr_i[`FPX_FPREG_HI:`FPX_FPREG_LO];
    assign low_bit        = instr_i[`FPX_LOW_BIT];

    // core register numbers; any two values, adjacent or not
    assign first_reg_num  = instr_i[`FPX_FIRST_HI:`FPX_FIRST_LO];
    assign second_reg_num = instr_i[`FPX_SECOND_HI:`FPX_SECOND_LO];

    // instruction class and precision decode
    // a word with a set bit in the zero slots, a clear one bit, or a
    // precision other than the two listed belongs to some other transfer
    // and must fall through untouched for a different decoder to take
    assign class_hit   = class_field == `FPX_CLASS_TWO_REG;
    assign prec_double = prec_field == `FPX_PREC_DOUBLE;
    assign prec_single = prec_field == `FPX_PREC_SINGLE;
    assign fixed_ok    = (zero_field == `FPX_ZERO_FIELD) && one_bit;
    // an encoding counts as a pair transfer only if class, precision and the
    // fixed bits all match; anything else is refused and touches nothing
    // double forms carry zero in the low-bit slot as well
    assign is_pair     = class_hit && fixed_ok
                         && (prec_single || (prec_double && !instr_i[`FPX_LOW_BIT]));
    assign dir_to_core = instr_i[`FPX_DIR_BIT] == `FPX_DIR_TO_CORE;

    // the four transfer kinds, condition aside
    // naming each kind keeps the direction and precision tests in one place;
    // the write and read strobes below are built from these and nothing else
    assign move_double_from_core_pair  = is_pair && prec_double && !dir_to_core;
    assign move_double_to_core_pair    = is_pair && prec_double && dir_to_core;
    assign move_singles_from_core_pair = is_pair && prec_single && !dir_to_core;
    assign move_singles_to_core_pair   = is_pair && prec_single && dir_to_core;

    // kinds fold onto the generic two-register write and read forms
    assign coproc_two_reg_write = move_double_from_core_pair
                                  || move_singles_from_core_pair;
    assign coproc_two_reg_read  = move_double_to_core_pair
                                  || move_singles_to_core_pair;

    ////////////////////////////////////////////////////////////////////////////
    // condition check against the core flags
    // flags come from the core on this clock, so they need no synchroniser;
    // they must be the flags that apply to the instruction offered with them
    // n, z, c and v sit at bits 3 down to 0 of core_flags_i
    assign cond = instr_i[`FPX_COND_HI:`FPX_COND_LO];
    assign n_f  = core_flags_i[`FPX_FLAG_N];
    assign z_f  = core_flags_i[`FPX_FLAG_Z];
    assign c_f  = core_flags_i[`FPX_FLAG_C];
    assign v_f  = core_flags_i[`FPX_FLAG_V];

    // flag tests, one per condition code
    assign cc_eq = z_f;
    assign cc_ne = !z_f;
    assign cc_cs = c_f;
    assign cc_cc = !c_f;
    assign cc_mi = n_f;
    assign cc_pl = !n_f;
    assign cc_vs = v_f;
    assign cc_vc = !v_f;
    assign cc_hi = c_f && !z_f;
    assign cc_ls = !c_f || z_f;
    assign cc_ge = n_f == v_f;
    assign cc_lt = n_f != v_f;
    assign cc_gt = !z_f && cc_ge;
    assign cc_le = z_f || cc_lt;

    // pick the test named by the condition field; an instruction written
    // without a condition arrives here already encoded as always
    always @* begin
        case (cond)
            `FPX_CC_EQ: cond_pass = cc_eq;
            `FPX_CC_NE: cond_pass = cc_ne;
            `FPX_CC_CS: cond_pass = cc_cs;
            `FPX_CC_CC: cond_pass = cc_cc;
            `FPX_CC_MI: cond_pass = cc_mi;
            `FPX_CC_PL: cond_pass = cc_pl;
            `FPX_CC_VS: cond_pass = cc_vs;
            `FPX_CC_VC: cond_pass = cc_vc;
            `FPX_CC_HI: cond_pass = cc_hi;
            `FPX_CC_LS: cond_pass = cc_ls;
            `FPX_CC_GE: cond_pass = cc_ge;
            `FPX_CC_LT: cond_pass = cc_lt;
            `FPX_CC_GT: cond_pass = cc_gt;
            `FPX_CC_LE: cond_pass = cc_le;
            `FPX_CC_AL: cond_pass = 1'b1;
            default:    cond_pass = 1'b0; // 1111 is not a conditional form
        endcase
    end

    // accept any pair-class word; it only acts when the condition passes
    // a failed condition is still accepted, so the core can retire the
    // instruction, but it neither writes nor raises read_valid_o
    assign instr_accept_o = instr_valid_i && is_pair && rst_n;
    assign go             = instr_accept_o && cond_pass;
    assign write_done_o   = go && coproc_two_reg_write;

    ////////////////////////////////////////////////////////////////////////////
    // single index: double d covers S(2d) low and S(2d+1) high
    // an index of 31 wraps its partner to 0; the core never issues it
    // the wrap is harmless to the file itself: both ports still name distinct
    // words, so the two writes of one edge never collide
    // the field sits above the low bit, so singles S(2k) and S(2k+1) share
    // their upper four index bits with double k
    assign base_idx = prec_double
                      ? {fp_field, 1'b0}
                      : {fp_field, low_bit};
    assign next_idx = base_idx + {{(AW-1){1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // register file: port a holds the first word, port b the second
    // words pass unaltered in both directions
    // the write enable is the qualified write strobe, so a refused or failed
    // instruction can never disturb the file
    // reads are not gated: the read ports follow the index every cycle
    fpx_regfile #(
        .AW (AW),
        .DW (DW)
    ) u_regfile (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .we_i      (write_done_o),
        .addr_a_i  (base_idx),
        .addr_b_i  (next_idx),
        .wdata_a_i (first_core_data_i),
        .wdata_b_i (second_core_data_i),
        .rdata_a_o (rd_a),
        .rdata_b_o (rd_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // timing seen by the core:
    // - a write is taken on the edge that ends the cycle in which
    //   write_done_o is high; both words land in that same edge
    // - a read is answered one cycle later with read_valid_o high for one
    //   cycle; data and register numbers are valid together with it
    // - transfers may follow each other every cycle; a read straight after
    //   a write to the same words sees the new words, as the write lands first
    // - condition code 1111 is not a conditional form here and never passes
    // - register numbers hold until the next passed transfer of either kind
    // read answer one cycle after acceptance, with core register numbers
    // no status or exception state exists here, so none can change
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            read_valid_o      <= 1'b0;
            first_core_reg_o  <= `FPX_REGNUM_RST;
            second_core_reg_o <= `FPX_REGNUM_RST;
        end else if (!rst_n) begin
            read_valid_o      <= 1'b0;
            first_core_reg_o  <= `FPX_REGNUM_RST;
            second_core_reg_o <= `FPX_REGNUM_RST;
        end else begin
            read_valid_o <= go && coproc_two_reg_read;
            if (go) begin
                first_core_reg_o  <= first_reg_num;
                second_core_reg_o <= second_reg_num;
            end
        end
    end

    // data outputs follow the registered read ports
    // they change whenever the read ports do, so the core samples them only
    // while read_valid_o is high
    always @* begin
        first_core_data_o  = rd_a;
        second_core_data_o = rd_b;
    end

endmodule

// ---- rtl/fpx_regs.vh ----
// constants for the floating-point pair transfer decoder
`ifndef FPX_REGS_VH
`define FPX_REGS_VH

// instruction field positions
`define FPX_COND_HI        31
`define FPX_COND_LO        28
`define FPX_CLASS_HI       27
`define FPX_CLASS_LO       21
`define FPX_DIR_BIT        20
`define FPX_SECOND_HI      19
`define FPX_SECOND_LO      16
`define FPX_FIRST_HI       15
`define FPX_FIRST_LO       12
`define FPX_PREC_HI        11
`define FPX_PREC_LO        8
`define FPX_ZERO_HI        7
`define FPX_ZERO_LO        6
`define FPX_LOW_BIT        5
`define FPX_ONE_BIT        4
`define FPX_FPREG_HI       3
`define FPX_FPREG_LO       0

// field values
`define FPX_CLASS_TWO_REG  7'h62
`define FPX_PREC_DOUBLE    4'hb
`define FPX_PREC_SINGLE    4'ha
`define FPX_ZERO_FIELD     2'h0
`define FPX_DIR_FROM_CORE  1'h0
`define FPX_DIR_TO_CORE    1'h1

// condition codes
`define FPX_CC_EQ          4'h0
`define FPX_CC_NE          4'h1
`define FPX_CC_CS          4'h2
`define FPX_CC_CC          4'h3
`define FPX_CC_MI          4'h4
`define FPX_CC_PL          4'h5
`define FPX_CC_VS          4'h6
`define FPX_CC_VC          4'h7
`define FPX_CC_HI          4'h8
`define FPX_CC_LS          4'h9
`define FPX_CC_GE          4'ha
`define FPX_CC_LT          4'hb
`define FPX_CC_GT          4'hc
`define FPX_CC_LE          4'hd
`define FPX_CC_AL          4'he

// flag positions in the core flag input
`define FPX_FLAG_N         3
`define FPX_FLAG_Z         2
`define FPX_FLAG_C         1
`define FPX_FLAG_V         0

// reset values
`define FPX_WORD_RST       32'h00000000
`define FPX_REGNUM_RST     4'h0

`endif

// ---- rtl/fpx_regfile.v ----
// single-precision register file, two write and two registered read ports
`timescale 1ns/1ps
module fpx_regfile #(
    parameter AW = 5,
    parameter DW = 32
) (
    input  wire          clk_sys_i,
    input  wire          rst_n_i,
    input  wire          we_i,
    input  wire [AW-1:0] addr_a_i,
    input  wire [AW-1:0] addr_b_i,
    input  wire [DW-1:0] wdata_a_i,
    input  wire [DW-1:0] wdata_b_i,
    output reg  [DW-1:0] rdata_a_o,
    output reg  [DW-1:0] rdata_b_o
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    ////////////////////////////////////////////////////////////////////////////
    // storage: both words written in the same edge, ports never share an index
    always @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[addr_a_i] <= wdata_a_i;
            mem[addr_b_i] <= wdata_b_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered read data, old contents on a same-cycle write
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_a_o <= {DW{1'b0}};
            rdata_b_o <= {DW{1'b0}};
        end else begin
            rdata_a_o <= mem[addr_a_i];
            rdata_b_o <= mem[addr_b_i];
        end
    end

endmodule

// ---- tb/fpx_pair_xfer_props.sv ----
// port assertions for the pair transfer decoder
`timescale 1ns/1ps
module fpx_pair_xfer_props (
    input wire        clk_sys_i,
    input wire        nrst_i,
    input wire        instr_valid_i,
    input wire [31:0] instr_i,
    input wire        instr_accept_o,
    input wire        write_done_o,
    input wire        read_valid_o,
    input wire [3:0]  first_core_reg_o,
    input wire [3:0]  second_core_reg_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    property p_rd; instr_accept_o && instr_i[20] && instr_i[31:28] == 4'he |=> read_valid_o; endproperty
    a_rd: assert property (p_rd) else $error("read answer missing");
    property p_rv; read_valid_o |-> $past(instr_accept_o) && $past(instr_i[20]); endproperty
    a_rv: assert property (p_rv) else $error("read answer without read");
    property p_wd; write_done_o |-> instr_accept_o && !instr_i[20]; endproperty
    a_wd: assert property (p_wd) else $error("write on wrong direction");
    property p_nv; instr_accept_o && instr_i[31:28] == 4'hf |-> !write_done_o ##1 !read_valid_o; endproperty
    a_nv: assert property (p_nv) else $error("never condition acted");
    property p_pr; instr_accept_o |-> instr_i[11:9] == 3'h5 && instr_i[7:6] == 2'h0 && instr_i[4]; endproperty
    a_pr: assert property (p_pr) else $error("bad precision field accepted");
    property p_cl; instr_accept_o |-> instr_valid_i && instr_i[27:21] == 7'h62; endproperty
    a_cl: assert property (p_cl) else $error("bad class accepted");
    property p_rg; read_valid_o |-> first_core_reg_o == $past(instr_i[15:12]) && second_core_reg_o == $past(instr_i[19:16]); endproperty
    a_rg: assert property (p_rg) else $error("core register numbers wrong");
    property p_db; instr_accept_o && instr_i[8] |-> !instr_i[5]; endproperty
    a_db: assert property (p_db) else $error("double with low bit accepted");
endmodule
bind fpx_pair_xfer fpx_pair_xfer_props u_props (.clk_sys_i, .nrst_i, .instr_valid_i, .instr_i,
    .instr_accept_o, .write_done_o, .read_valid_o, .first_core_reg_o, .second_core_reg_o);

// ---- tb/fpx_core_model.sv ----
// integer core model: operand words out, read answers written back
`timescale 1ns/1ps
module fpx_core_model (
    input  wire        clk_sys_i,
    input  wire [31:0] instr_i,
    input  wire        ans_vld_i,
    input  wire [3:0]  ans_ra_i,
    input  wire [3:0]  ans_rb_i,
    input  wire [31:0] ans_a_i,
    input  wire [31:0] ans_b_i,
    output wire [31:0] op_a_o,
    output wire [31:0] op_b_o
);
    logic [31:0] regs [16];
    // operands picked by the two core register fields
    assign op_a_o = regs[instr_i[15:12]];
    assign op_b_o = regs[instr_i[19:16]];
    // answers land in the named core registers
    always @(posedge clk_sys_i) begin
        if (ans_vld_i) begin
            regs[ans_ra_i] <= ans_a_i;
            regs[ans_rb_i] <= ans_b_i;
        end
    end
endmodule

// ---- tb/fpx_pair_xfer_tb.sv ----
// self-checking bench for the pair transfer decoder
`timescale 1ns/1ps
module fpx_pair_xfer_tb;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        instr_valid_i = 1'b0;
    logic [31:0] instr_i = 32'h0;
    logic [3:0]  core_flags_i = 4'h0;
    wire  [31:0] fd_i, sd_i, fd_o, sd_o;
    wire  [3:0]  fr_o, sr_o;
    wire         acc_o, wd_o, rv_o;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    fpx_pair_xfer uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .core_flags_i(core_flags_i), .first_core_data_i(fd_i),
        .second_core_data_i(sd_i), .instr_accept_o(acc_o), .write_done_o(wd_o),
        .read_valid_o(rv_o), .first_core_data_o(fd_o), .second_core_data_o(sd_o),
        .first_core_reg_o(fr_o), .second_core_reg_o(sr_o));
    fpx_core_model core (.clk_sys_i(clk_sys_i), .instr_i(instr_i), .ans_vld_i(rv_o),
        .ans_ra_i(fr_o), .ans_rb_i(sr_o), .ans_a_i(fd_o), .ans_b_i(sd_o), .op_a_o(fd_i),
        .op_b_o(sd_i));
    always #10 clk_sys_i = ~clk_sys_i;
    // cut a hang short
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] mk(input logic [3:0] cc, input logic dir,
        input logic [3:0] rn, input logic [3:0] rd, input logic dbl, input logic [4:0] m);
        return {cc, 7'h62, dir, rn, rd, 3'h5, dbl, 2'h0, m[0], 1'b1, m[4:1]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic iss(input logic [31:0] i);
        instr_valid_i <= 1'b1;
        instr_i <= i;
        @(posedge clk_sys_i);
    endtask
    task automatic idle;
        instr_valid_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask
    task automatic summarize;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // double write from r1/r7, read back and as two singles; no r15 target
    task automatic t_double;
        core.regs[1] <= 32'h0123_4567;
        core.regs[7] <= 32'h89ab_cdef;
        iss(mk(4'he, 1'b0, 4'h7, 4'h1, 1'b1, 5'h6));
        iss(mk(4'he, 1'b1, 4'h2, 4'h9, 1'b1, 5'h6));
        iss(mk(4'he, 1'b1, 4'h4, 4'h3, 1'b0, 5'h6));
        idle();
        chk(core.regs[9], 32'h0123_4567);
        chk(core.regs[2], 32'h89ab_cdef);
        chk(core.regs[3], 32'h0123_4567);
        chk(core.regs[4], 32'h89ab_cdef);
    endtask
    // single pairs at several starts, never S31
    task automatic t_single;
        logic [4:0] ms [4] = '{5'h00, 5'h01, 5'h11, 5'h1c};
        foreach (ms[k]) begin
            core.regs[4] <= 32'ha5a5_0000 + ms[k];
            core.regs[11] <= 32'h5a5a_ff00 - ms[k];
            iss(mk(4'he, 1'b0, 4'hb, 4'h4, 1'b0, ms[k]));
            iss(mk(4'he, 1'b1, 4'hc, 4'h5, 1'b0, ms[k]));
            iss(mk(4'he, 1'b1, 4'h7, 4'h6, 1'b0, ms[k] + 5'h1));
            idle();
            chk(core.regs[5], 32'ha5a5_0000 + ms[k]);
            chk(core.regs[12], 32'h5a5a_ff00 - ms[k]);
            chk(core.regs[6], 32'h5a5a_ff00 - ms[k]);
        end
    endtask
    // conditional writes: {cond, flags, passes}
    task automatic t_cond;
        logic [8:0]  tab [6] = '{9'h009, 9'h000, 9'h153, 9'h150, 9'h1fe, 9'h021};
        logic [31:0] exp = 32'h0;
        core.regs[8] <= 32'h0;
        iss(mk(4'he, 1'b0, 4'h8, 4'h8, 1'b0, 5'h14));
        foreach (tab[k]) begin
            core.regs[8] <= 32'hc0de_0000 + k;
            core_flags_i <= tab[k][4:1];
            iss(mk(tab[k][8:5], 1'b0, 4'h8, 4'h8, 1'b0, 5'h14));
            chk({31'h0, wd_o}, {31'h0, tab[k][0]});
            chk({31'h0, acc_o}, 32'h1);
            iss(mk(4'he, 1'b1, 4'he, 4'hd, 1'b0, 5'h14));
            idle();
            if (tab[k][0]) exp = 32'hc0de_0000 + k;
            chk(core.regs[13], exp);
        end
    endtask
    // foreign encodings are refused and change nothing
    task automatic t_refuse;
        core.regs[10] <= 32'h5a5a_5a5a;
        iss(mk(4'he, 1'b1, 4'h0, 4'ha, 1'b0, 5'h4) | 32'h40);
        chk({31'h0, acc_o}, 32'h0);
        iss(mk(4'he, 1'b1, 4'h0, 4'ha, 1'b1, 5'h4) ^ 32'h0020_0000);
        chk({31'h0, acc_o}, 32'h0);
        idle();
        chk(core.regs[10], 32'h5a5a_5a5a);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_double();
        t_single();
        t_cond();
        t_refuse();
        summarize();
    end
endmodule
